// ===== core/sbdma_device.sv
// sbdma_device: system bus side of the network controller: register write
// acknowledge, bus request, T1-T4 master cycles, wait states, remote port.
// assumes access, grant and ack pins are async and synchronised here; ready
// is timed to clk with setup before T3 and is read directly.
//
// Summary of operation
// - acknowledge only after cs and write synchronised
// - acknowledge waits for running dma transfer
// - either cs or strobe may arrive last
// - select latched on strobe fall, else transparent
// - missed grant slips dma start four clocks
// - remote one transfer, local bursts
// - primed states only before first transfer
// - byte mode holds upper address through burst
// - ready sampled at T3 adds waits
// - memory keeps waits within network limits
// - wait limit from network and bus periods
// - bus clock period between 50 and 125 ns; package and bench use a 40 ns period
// - latency picks threshold and burst mode; here BURST_LEN alone fixes the local burst and no threshold is kept
// - request on clock edge, release after transfer
// - remote waits ack before next transfer
// - host stalls cpu until acknowledge low
// - remote ack high seven clocks between
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sbdma_device
   import sbdma_pkg::*;
#(
   parameter int BURST_LEN = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins toward host, memory and arbiter
   sbdma_if.device bus,
   // user side: dma orders from the network core
   input wire logic dma_start,
   input wire logic dma_remote,
   input wire logic dma_write,
   input wire logic byte_mode,
   input wire logic mode32,
   input wire logic [ADDR_W-1:0] dma_addr,
   output logic dma_done,
   // user side: register writes seen by the core
   output logic reg_wr,
   output logic [REGSEL_W-1:0] reg_wr_sel,
   output logic [7:0] reg_wr_data
);
   // two-flop synchronisers for async pins; first stage read only by second
   logic [3:0] s1_reg, s2_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // grant idles low, so no false grant right after reset
         s1_reg <= 4'hd;
         s2_reg <= 4'hd;
      end
      else
      begin
         s1_reg <= {bus.cs_n, bus.slave_write_strobe_n, bus.bus_grant, bus.remote_read_ack_n};
         s2_reg <= s1_reg;
      end
   end
   // synchronised views
   logic cs_s, swr_s, rdy_s, gnt_s, remote_read_ack_s;
   assign cs_s = ~s2_reg[3];
   assign swr_s = ~s2_reg[2];
   // ready meets setup to T3; two sync flops would see it too late
   assign rdy_s = bus.ready;
   assign gnt_s = s2_reg[1];
   assign remote_read_ack_s = ~s2_reg[0];

   // select latch: captured while strobe low-going, transparent when high
   logic [REGSEL_W-1:0] sel_latch;
   always_latch
   begin
      if (bus.addr_latch_strobe)
         sel_latch = bus.reg_select_lines;
   end

   // register access state
   logic ack_reg, ack_next, wr_reg, wr_next;
   logic [REGSEL_W-1:0] sel_reg, sel_next;
   logic [7:0] wd_reg, wd_next;
   // dma state
   sbdma_state_t st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] beat_reg, beat_next;
   logic [ADDR_W-1:0] a_reg, a_next;
   logic first_reg, first_next;
   logic brq_reg, brq_next, as_reg, as_next, rd_reg, rd_next, wrs_reg, wrs_next;
   logic oe_reg, oe_next, hi_reg, hi_next, pwr_reg, pwr_next, prq_reg, prq_next;
   logic done_reg, done_next;
   logic rem_reg, rem_next, dw_reg, dw_next, bm_reg, bm_next, m32_reg, m32_next;
   logic busy;
   assign busy = (st_reg inside {SB_T1, SB_T2, SB_T3, SB_TW, SB_T4, SB_P1, SB_P2, SB_P3,
                                 SB_P4});

   // next-state for register access and dma engine
   always_comb
   begin
      ack_next = ack_reg;
      wr_next = 1'b0;
      sel_next = sel_reg;
      wd_next = wd_reg;
      // acknowledge once both synchronised strobes are low
      // whichever falls last starts the count, both are required
      // held off while a dma transfer is on the bus
      if (cs_s && swr_s && !ack_reg && !busy)
      begin
         ack_next = 1'b1;
         wr_next = 1'b1;
         sel_next = sel_latch;
         wd_next = bus.reg_wdata;
      end
      else if (!(cs_s && swr_s))
         ack_next = 1'b0;
      st_next = st_reg;
      cnt_next = cnt_reg;
      beat_next = beat_reg;
      a_next = a_reg;
      first_next = first_reg;
      brq_next = brq_reg;
      as_next = 1'b0;
      rd_next = 1'b0;
      wrs_next = 1'b0;
      oe_next = oe_reg;
      hi_next = hi_reg;
      pwr_next = 1'b0;
      prq_next = prq_reg;
      done_next = 1'b0;
      rem_next = rem_reg;
      dw_next = dw_reg;
      bm_next = bm_reg;
      m32_next = m32_reg;
      case (st_reg)
         SB_IDLE:
         begin
            // request raised on a clock edge
            if (dma_start && !ack_reg)
            begin
               brq_next = 1'b1;
               rem_next = dma_remote;
               dw_next = dma_write;
               bm_next = byte_mode;
               m32_next = mode32;
               a_next = dma_addr;
               // remote is one transfer, local a burst
               beat_next = dma_remote ? 8'h01 : 8'(BURST_LEN);
               first_next = 1'b1;
               st_next = SB_REQ;
            end
         end
         SB_REQ:
         begin
            // grant present at T1 edge, else slip four clocks
            if (gnt_s)
            begin
               oe_next = 1'b1;
               st_next = m32_reg ? SB_P1 : SB_T1;
            end
            else
            begin
               cnt_next = 4'(GRANT_SLIP_CYCLES - 1);
               st_next = SB_SLIP;
            end
         end
         SB_SLIP:
         begin
            if (cnt_reg != 4'h0)
               cnt_next = cnt_reg - 4'h1;
            else
               st_next = SB_REQ;
         end
         // primed address states only before first transfer
         SB_P1: st_next = SB_P2;
         SB_P2: st_next = SB_P3;
         SB_P3: st_next = SB_P4;
         SB_P4: st_next = SB_T1;
         SB_T1:
         begin
            as_next = 1'b1;
            hi_next = 1'b1;
            first_next = 1'b0;
            st_next = SB_T2;
         end
         SB_T2:
         begin
            rd_next = !dw_reg;
            wrs_next = dw_reg;
            st_next = SB_T3;
         end
         SB_T3, SB_TW:
         begin
            rd_next = !dw_reg;
            wrs_next = dw_reg;
            // ready low at T3 inserts waits
            st_next = rdy_s ? SB_T4 : SB_TW;
         end
         SB_T4:
         begin
            a_next = a_reg + (bm_reg ? 16'h0001 : 16'h0002);
            beat_next = beat_reg - 8'h01;
            if (beat_reg == 8'h01)
            begin
               // upper byte released after last transfer in both byte and word mode
               hi_next = 1'b0;
               oe_next = 1'b0;
               brq_next = 1'b0;
               st_next = rem_reg ? SB_PORT : SB_REL;
               pwr_next = rem_reg;
            end
            else
            begin
               // byte mode keeps the upper byte driven
               hi_next = bm_reg;
               st_next = SB_T1;
            end
         end
         SB_PORT:
         begin
            // port request until remote ack seen
            prq_next = 1'b1;
            if (remote_read_ack_s)
            begin
               prq_next = 1'b0;
               st_next = SB_REL;
            end
         end
         SB_REL:
         begin
            done_next = 1'b1;
            st_next = SB_IDLE;
         end
         default: st_next = SB_IDLE;
      endcase
   end

   // register stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ack_reg <= 1'b0;
         wr_reg <= 1'b0;
         sel_reg <= '0;
         wd_reg <= 8'h00;
         st_reg <= SB_IDLE;
         cnt_reg <= 4'h0;
         beat_reg <= 8'h00;
         a_reg <= '0;
         first_reg <= 1'b0;
         brq_reg <= 1'b0;
         as_reg <= 1'b0;
         rd_reg <= 1'b0;
         wrs_reg <= 1'b0;
         oe_reg <= 1'b0;
         hi_reg <= 1'b0;
         pwr_reg <= 1'b0;
         prq_reg <= 1'b0;
         done_reg <= 1'b0;
         rem_reg <= 1'b0;
         dw_reg <= 1'b0;
         bm_reg <= 1'b0;
         m32_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= ack_next;
         wr_reg <= wr_next;
         sel_reg <= sel_next;
         wd_reg <= wd_next;
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         beat_reg <= beat_next;
         a_reg <= a_next;
         first_reg <= first_next;
         brq_reg <= brq_next;
         as_reg <= as_next;
         rd_reg <= rd_next;
         wrs_reg <= wrs_next;
         oe_reg <= oe_next;
         hi_reg <= hi_next;
         pwr_reg <= pwr_next;
         prq_reg <= prq_next;
         done_reg <= done_next;
         rem_reg <= rem_next;
         dw_reg <= dw_next;
         bm_reg <= bm_next;
         m32_reg <= m32_next;
      end
   end

   // pin and user outputs straight from flops
   assign bus.ack_n = ~ack_reg;
   assign bus.bus_request_out = brq_reg;
   assign bus.addr_out = a_reg;
   assign bus.addr_lo_oe_n = ~oe_reg;
   assign bus.upper_address_byte_oe_n = ~hi_reg;
   assign bus.addr_strobe = as_reg;
   assign bus.mem_read_strobe_n = ~rd_reg;
   assign bus.memory_write_strobe_n = ~wrs_reg;
   assign bus.ctrl_oe_n = ~oe_reg;
   assign bus.port_write_strobe_n = ~pwr_reg;
   assign bus.port_request = prq_reg;
   assign dma_done = done_reg;
   assign reg_wr = wr_reg;
   assign reg_wr_sel = sel_reg;
   assign reg_wr_data = wd_reg;
endmodule
`default_nettype wire

// ===== shared/sbdma_pkg.sv
// sbdma_pkg: constants and types shared by both ends of the system bus dma link.
// assumes one 25 MHz bus clock feeds both ends; no registers are mapped here.
package sbdma_pkg;
   // bus clock period in ns and wait-limit figures
   localparam int CLK_PERIOD_NS = 40;
   // slipped dma start after a missed grant, in bus clocks
   localparam int GRANT_SLIP_CYCLES = 4;
   // least remote read acknowledge high time between transfers
   localparam int REMOTE_READ_ACK_HIGH_MIN = 7;
   // register access synchroniser depth
   localparam int SYNC_STAGES = 2;
   // address and data widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int REGSEL_W = 4;
   // default wait limit for a 25 MHz bus and 10 MHz network, word mode
   localparam int WAIT_LIMIT_WORD = 5;
   localparam int WAIT_LIMIT_BYTE = 3;
   // host command codes
   localparam logic [1:0] CMD_IDLE = 2'h0;
   localparam logic [1:0] CMD_LOCAL = 2'h1;
   localparam logic [1:0] CMD_REMOTE = 2'h2;
   // bus cycle states
   typedef enum logic [3:0]
   {
      SB_IDLE = 4'h0,
      SB_REQ = 4'h1,
      SB_SLIP = 4'h2,
      SB_P1 = 4'h3,
      SB_P2 = 4'h4,
      SB_P3 = 4'h5,
      SB_P4 = 4'h6,
      SB_T1 = 4'h7,
      SB_T2 = 4'h8,
      SB_T3 = 4'h9,
      SB_TW = 4'ha,
      SB_T4 = 4'hb,
      SB_PORT = 4'hc,
      SB_REL = 4'hd
   } sbdma_state_t;
endpackage

// ===== shared/sbdma_if.sv
// sbdma_if: pins between the dma device and its host, memory and arbiter.
// assumes both ends share clk; three-state pins carry only an output and an enable, no input.
`timescale 1ns/1ps
`default_nettype none
interface sbdma_if;
   import sbdma_pkg::*;
   // slave register access
   logic cs_n;
   logic slave_write_strobe_n;
   logic addr_latch_strobe;
   logic [REGSEL_W-1:0] reg_select_lines;
   logic [7:0] reg_wdata;
   logic ack_n;
   // arbitration
   logic bus_request_out;
   logic bus_grant;
   // master bus cycle
   logic [ADDR_W-1:0] addr_out;
   logic addr_lo_oe_n;
   logic upper_address_byte_oe_n;
   logic addr_strobe;
   logic mem_read_strobe_n;
   logic memory_write_strobe_n;
   logic ctrl_oe_n;
   logic ready;
   // remote dma port
   logic port_write_strobe_n;
   logic port_request;
   logic remote_read_ack_n;
   modport device
   (
      input cs_n, slave_write_strobe_n, addr_latch_strobe, reg_select_lines, reg_wdata,
      output ack_n,
      output bus_request_out,
      input bus_grant,
      output addr_out, addr_lo_oe_n, upper_address_byte_oe_n, addr_strobe,
      output mem_read_strobe_n, memory_write_strobe_n, ctrl_oe_n,
      input ready,
      output port_write_strobe_n, port_request,
      input remote_read_ack_n
   );
   modport host
   (
      output cs_n, slave_write_strobe_n, addr_latch_strobe, reg_select_lines, reg_wdata,
      input ack_n,
      input bus_request_out,
      output bus_grant,
      input addr_out, addr_lo_oe_n, upper_address_byte_oe_n, addr_strobe,
      input mem_read_strobe_n, memory_write_strobe_n, ctrl_oe_n,
      output ready,
      input port_write_strobe_n, port_request,
      output remote_read_ack_n
   );
endinterface
`default_nettype wire

// ===== core/sbdma_host.sv
// sbdma_host: host cpu write port, arbiter, zero/limited-wait memory ready and
// remote port acknowledge. assumes device pins change only on clk edges.
`timescale 1ns/1ps
`default_nettype none
module sbdma_host
   import sbdma_pkg::*;
#(
   parameter int WAIT_STATES = 1
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins toward the device
   sbdma_if.host bus,
   // user side: cpu write request
   input wire logic cpu_wr,
   input wire logic cpu_latched,
   input wire logic [REGSEL_W-1:0] cpu_sel,
   input wire logic [7:0] cpu_data,
   output logic cpu_busy
);
   // cpu state, grant, ready, remote ack
   logic cs_reg, cs_next, sw_reg, sw_next, als_reg, als_next, busy_reg, busy_next;
   logic [REGSEL_W-1:0] sel_reg, sel_next;
   logic [7:0] d_reg, d_next;
   logic gnt_reg, gnt_next, rdy_reg, rdy_next, rk_reg, rk_next;
   logic [3:0] w_reg, w_next, rh_reg, rh_next;
   // latched select mode of the access in progress
   logic lat_reg, lat_next;

   // next values
   always_comb
   begin
      cs_next = cs_reg;
      sw_next = sw_reg;
      als_next = 1'b1;
      busy_next = busy_reg;
      sel_next = sel_reg;
      d_next = d_reg;
      lat_next = lat_reg;
      // cpu held in wait until acknowledge low
      if (!busy_reg && cpu_wr)
      begin
         busy_next = 1'b1;
         cs_next = 1'b1;
         sw_next = 1'b1;
         sel_next = cpu_sel;
         d_next = cpu_data;
         lat_next = cpu_latched;
      end
      else if (busy_reg && !bus.ack_n)
      begin
         cs_next = 1'b0;
         sw_next = 1'b0;
         busy_next = 1'b0;
      end
      else if (busy_reg && lat_reg)
      begin
         // strobe falls after select settled, then lines are scrambled
         als_next = 1'b0;
         if (!als_reg)
            sel_next = ~sel_reg;
      end
      gnt_next = bus.bus_request_out;
      // wait states bounded by WAIT_STATES
      // ready drops on the address phase so that it stands at T3
      rdy_next = rdy_reg;
      w_next = w_reg;
      if (bus.addr_strobe)
      begin
         w_next = 4'h0;
         rdy_next = (WAIT_STATES == 0);
      end
      else if (!rdy_reg)
      begin
         w_next = w_reg + 4'h1;
         rdy_next = ((w_reg + 4'h1) >= 4'(WAIT_STATES));
      end
      // ack pulse, then held high seven clocks
      rk_next = 1'b0;
      rh_next = (rh_reg != 4'h0) ? rh_reg - 4'h1 : 4'h0;
      if (bus.port_request && rh_reg == 4'h0 && !rk_reg)
      begin
         rk_next = 1'b1;
         rh_next = 4'(REMOTE_READ_ACK_HIGH_MIN);
      end
   end

   // register stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cs_reg <= 1'b0;
         sw_reg <= 1'b0;
         als_reg <= 1'b1;
         busy_reg <= 1'b0;
         sel_reg <= '0;
         d_reg <= 8'h00;
         lat_reg <= 1'b0;
         gnt_reg <= 1'b0;
         rdy_reg <= 1'b1;
         w_reg <= 4'h0;
         rk_reg <= 1'b0;
         rh_reg <= 4'h0;
      end
      else
      begin
         cs_reg <= cs_next;
         sw_reg <= sw_next;
         als_reg <= als_next;
         busy_reg <= busy_next;
         sel_reg <= sel_next;
         d_reg <= d_next;
         lat_reg <= lat_next;
         gnt_reg <= gnt_next;
         rdy_reg <= rdy_next;
         w_reg <= w_next;
         rk_reg <= rk_next;
         rh_reg <= rh_next;
      end
   end

   // outputs from flops
   assign bus.cs_n = ~cs_reg;
   assign bus.slave_write_strobe_n = ~sw_reg;
   assign bus.addr_latch_strobe = als_reg;
   assign bus.reg_select_lines = sel_reg;
   assign bus.reg_wdata = d_reg;
   assign bus.bus_grant = gnt_reg;
   assign bus.ready = rdy_reg;
   assign bus.remote_read_ack_n = ~rk_reg;
   assign cpu_busy = busy_reg;
endmodule
`default_nettype wire

// ===== sim/sbdma_assertions.sv
// sbdma_assertions: pin-level checks on the link between device and host.
// assumes one clock, rst async high; placed beside the interface by the bench.
`timescale 1ns/1ps
`default_nettype none
module sbdma_assertions
   import sbdma_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access pins
   input wire logic cs_n,
   input wire logic slave_write_strobe_n,
   input wire logic ack_n,
   // master cycle pins
   input wire logic bus_request_out,
   input wire logic bus_grant,
   input wire logic addr_strobe,
   input wire logic mem_read_strobe_n,
   input wire logic memory_write_strobe_n,
   input wire logic ctrl_oe_n,
   input wire logic ready,
   // remote port pins
   input wire logic port_write_strobe_n,
   input wire logic port_request,
   input wire logic remote_read_ack_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // both access pins low at once
   wire logic wr_low = !cs_n && !slave_write_strobe_n;
   // either data strobe active
   wire logic dstb = !mem_read_strobe_n || !memory_write_strobe_n;
   // a one-cycle address phase
   sequence s_t1;
      addr_strobe ##1 !addr_strobe;
   endsequence
   // port write pulse followed by the request
   sequence s_port;
      port_write_strobe_n ##[0:2] port_request;
   endsequence
   // ack only after the access has stood through the sync stages
   a_ack_synced: assert property ($fell(ack_n) |-> $past(wr_low, 1) && $past(wr_low, 2))
      else $error("ack came before the access was synchronised");
   a_ack_no_dma: assert property ($fell(ack_n) |-> $past(ctrl_oe_n))
      else $error("ack given while a transfer held the bus");
   a_ack_release: assert property (!ack_n && !wr_low |-> ##[1:4] ack_n)
      else $error("ack did not clear after the access ended");
   a_t1_granted: assert property (addr_strobe |-> bus_grant && bus_request_out)
      else $error("address phase without grant");
   a_req_ctrl_off: assert property ($rose(bus_request_out) |-> ctrl_oe_n)
      else $error("control driven before request");
   a_ctrl_release: assert property ($fell(bus_request_out) |-> ##[0:2] ctrl_oe_n)
      else $error("control not released after request");
   a_t1_then_strobe: assert property (s_t1 |-> ##[0:5] dstb)
      else $error("no data strobe after address phase");
   a_strobe_width: assert property ($rose(dstb) |=> dstb)
      else $error("data strobe shorter than two cycles");
   a_wait_stretch: assert property (dstb && !ready |=> dstb ##1 dstb)
      else $error("data strobe not stretched by wait");
   a_port_pulse: assert property ($fell(port_write_strobe_n) |=> s_port)
      else $error("port write not followed by port request");
   a_port_ack: assert property ($fell(port_request) |-> !$past(remote_read_ack_n, 2) || !$past(remote_read_ack_n, 3))
      else $error("port request dropped without acknowledge");
   a_port_no_cycle: assert property (port_request |-> !addr_strobe)
      else $error("next transfer began before acknowledge");
endmodule
`default_nettype wire

// ===== sim/sbdma_tb_top.sv
// sbdma_tb_top: drives the user sides of device and host joined by sbdma_if.
// assumes the host end answers grants, ready and the remote acknowledge.
`timescale 1ns/1ps
`default_nettype none
module sbdma_tb_top;
   import sbdma_pkg::*;
   // short burst keeps the run brief
   localparam int BURST = 4;
   // wait states the memory end inserts per transfer
   localparam int WAITS = 1;
   logic clk, rst, dma_start, dma_remote, dma_write, byte_mode, mode32, dma_done;
   logic [ADDR_W-1:0] dma_addr;
   logic reg_wr, cpu_wr, cpu_latched, cpu_busy;
   logic [REGSEL_W-1:0] reg_wr_sel, cpu_sel, got_sel;
   logic [7:0] reg_wr_data, cpu_data, got_data;
   logic prev_rd, prev_wr, prev_pw, prev_up;
   logic [15:0] addrs [$]; // address seen at each address phase
   int n_mismatch, checks, n_rd, n_wr, n_pw, n_up, n_done, n_regwr, i, n_lo, n_pre;
   logic [31:0] r;
   sbdma_if bus ();
   sbdma_device #(.BURST_LEN(BURST)) sbdma_device_i (.clk(clk), .rst(rst), .bus(bus),
      .dma_start(dma_start), .dma_remote(dma_remote), .dma_write(dma_write),
      .byte_mode(byte_mode), .mode32(mode32), .dma_addr(dma_addr), .dma_done(dma_done),
      .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data));
   sbdma_host #(.WAIT_STATES(WAITS)) sbdma_host_i (.clk(clk), .rst(rst), .bus(bus),
      .cpu_wr(cpu_wr), .cpu_latched(cpu_latched), .cpu_sel(cpu_sel), .cpu_data(cpu_data),
      .cpu_busy(cpu_busy));
   sbdma_assertions sbdma_assertions_i (.clk(clk), .rst(rst), .cs_n(bus.cs_n),
      .slave_write_strobe_n(bus.slave_write_strobe_n), .ack_n(bus.ack_n),
      .bus_request_out(bus.bus_request_out), .bus_grant(bus.bus_grant),
      .addr_strobe(bus.addr_strobe), .mem_read_strobe_n(bus.mem_read_strobe_n),
      .memory_write_strobe_n(bus.memory_write_strobe_n), .ctrl_oe_n(bus.ctrl_oe_n),
      .ready(bus.ready),
      .port_write_strobe_n(bus.port_write_strobe_n), .port_request(bus.port_request),
      .remote_read_ack_n(bus.remote_read_ack_n));
   // 25 MHz bus clock
   always #20 clk = ~clk;
   // monitor: counts strobe falls and captures what the core saw
   always @(posedge clk)
   begin
      if (reg_wr === 1'b1)
      begin
         got_sel = reg_wr_sel;
         got_data = reg_wr_data;
         n_regwr++;
      end
      if (dma_done === 1'b1) n_done++;
      // request cycles up to and including the first address phase
      if (bus.bus_request_out === 1'b1 && addrs.size() == 0) n_pre++;
      // data strobe cycles, stretched by waits
      if (!bus.mem_read_strobe_n || !bus.memory_write_strobe_n) n_lo++;
      if (bus.addr_strobe === 1'b1) addrs.push_back(bus.addr_out);
      if (prev_rd && !bus.mem_read_strobe_n) n_rd++;
      if (prev_wr && !bus.memory_write_strobe_n) n_wr++;
      if (prev_pw && !bus.port_write_strobe_n) n_pw++;
      if (!prev_up && bus.upper_address_byte_oe_n) n_up++;
      prev_rd = bus.mem_read_strobe_n;
      prev_wr = bus.memory_write_strobe_n;
      prev_pw = bus.port_write_strobe_n;
      prev_up = bus.upper_address_byte_oe_n;
   end
   // expected address of beat k: bytes step by one, words by two
   function automatic logic [15:0] exp_addr(input logic [15:0] base, input int k, input logic bm);
      exp_addr = base + (bm ? 16'(k) : 16'(2 * k));
   endfunction
   // compare of design values, four-state exact
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   // compare of counted events
   task automatic cmp_cnt(input int got, input int exp);
      checks++;
      if (got != exp)
      begin
         n_mismatch++;
         $display("Error at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task wrap_up;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // a bounded wait that ran out is a mismatch
   task automatic hang(input int k);
      if (k >= 600)
      begin
         n_mismatch++;
         $display("Error at %0t: wait ran out", $time);
         wrap_up();
      end
   endtask
   // one cpu register write, waits until ack has cleared again
   task reg_write(input logic lat, input logic [3:0] sel, input logic [7:0] d);
      int k;
      n_regwr = 0;
      cpu_latched <= lat;
      cpu_sel <= sel;
      cpu_data <= d;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
      k = 0;
      while (!(n_regwr > 0 && cpu_busy === 1'b0 && bus.ack_n === 1'b1) && k < 600)
      begin
         @(posedge clk);
         k++;
      end
      hang(k);
      cmp_cnt(n_regwr, 1);
      cmp_val(16'(got_sel), 16'(sel));
      cmp_val(16'(got_data), 16'(d));
   endtask
   // one dma order, checks beats, addresses, port pulses and release
   task run_dma(input logic rem, input logic wr, input logic bm, input logic m32,
      input logic [15:0] a);
      int k, beats, off;
      n_rd = 0;
      n_wr = 0;
      n_pw = 0;
      n_up = 0;
      n_done = 0;
      n_lo = 0;
      n_pre = 0;
      addrs.delete();
      dma_remote <= rem;
      dma_write <= wr;
      byte_mode <= bm;
      mode32 <= m32;
      dma_addr <= a;
      dma_start <= 1'b1;
      @(posedge clk);
      dma_start <= 1'b0;
      k = 0;
      while (n_done == 0 && k < 600)
      begin
         @(posedge clk);
         k++;
      end
      hang(k);
      repeat (4) @(posedge clk);
      beats = rem ? 1 : BURST;
      off = addrs.size() - beats;
      cmp_cnt(n_done, 1);
      cmp_cnt(wr ? n_wr : n_rd, beats);
      cmp_cnt(wr ? n_rd : n_wr, 0);
      cmp_cnt(n_pw, int'(rem));
      cmp_cnt(n_lo, beats * (2 + WAITS));
      // request, slipped start, request, primes, T1 and the address phase
      cmp_cnt(n_pre, GRANT_SLIP_CYCLES + 4 + (m32 ? 4 : 0));
      if (bm) cmp_cnt(n_up, 1);
      cmp_cnt((off < 0 || off > int'(m32)) ? 1 : 0, 0);
      for (k = 0; k < beats; k++) cmp_val(addrs[off + k], exp_addr(a, k, bm));
   endtask
   // main sequence
   initial
   begin
      {clk, dma_start, dma_remote, dma_write, byte_mode, mode32, cpu_wr, cpu_latched} = '0;
      {dma_addr, cpu_sel, cpu_data, n_mismatch, checks} = '0;
      {prev_rd, prev_wr, prev_pw, prev_up} = '1;
      rst = 1'b1;
      void'($urandom(70));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // corner values in both select modes, then random writes
      reg_write(1'b0, 4'hf, 8'h00);
      reg_write(1'b1, 4'h0, 8'hff);
      for (i = 0; i < 6; i++)
      begin
         r = $urandom;
         reg_write(r[0], r[7:4], r[15:8]);
      end
      // every mix of remote, direction, width and 32-bit priming
      for (i = 0; i < 16; i++)
      begin
         r = $urandom;
         run_dma(i[0], i[1], i[2], i[3], {r[15:1], 1'b0});
      end
      // register write landing in the middle of a transfer
      for (i = 0; i < 2; i++)
      begin
         r = $urandom;
         fork
            run_dma(i[0], r[1], r[2], 1'b0, 16'hfff8);
            begin
               repeat (4) @(posedge clk);
               reg_write(r[3], r[7:4], r[15:8]);
            end
         join
      end
      wrap_up();
   end
endmodule
`default_nettype wire
